// ==== logic/rfm_counter.sv ====
// one general 48-bit counter with enable, increment input and low and high word writes
`include "rfm_params.svh"
module rfm_counter
  import rfm_pkg::*;
#(
  parameter int CW = 48,
  parameter int FW = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [FW-1:0] inc,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  output logic [CW-1:0] count
);
  logic [CW-1:0] cnt_q;
  wire logic [CW-1:0] cnt_inc = cnt_q + CW'(inc);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (wr_lo) begin
      cnt_q <= {cnt_q[CW-1:32], wdata};
    end else if (wr_hi) begin
      cnt_q <= {wdata[CW-33:0], cnt_q[31:0]};
    end else if (enable) begin
      cnt_q <= cnt_inc;
    end
  end
  assign count = cnt_q;
endmodule

// ==== logic/rfm_fill_tracker.sv ====
// per class and virtual network occupancy of the receive flit queue
`include "rfm_params.svh"
module rfm_fill_tracker
  import rfm_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic alloc_valid,
  input wire logic [2:0] alloc_class,
  input wire logic alloc_vn,
  input wire logic free_valid,
  input wire logic [2:0] free_class,
  input wire logic free_vn,
  output logic [6*2*CW-1:0] fill_flat
);
  logic [CW-1:0] fill_q [12];
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_slot
      wire logic inc = alloc_valid && ({alloc_class, alloc_vn} == 4'(g));
      wire logic dec = free_valid && ({free_class, free_vn} == 4'(g));
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          fill_q[g] <= '0;
        end else if (inc && !dec) begin
          fill_q[g] <= fill_q[g] + CW'(1);
        end else if (dec && !inc && fill_q[g] != '0) begin
          fill_q[g] <= fill_q[g] - CW'(1);
        end
      end
      assign fill_flat[g*CW +: CW] = fill_q[g];
    end
  endgenerate
endmodule

// ==== logic/rfm_monitor.sv ====
// receive flit queue event monitor with Avalon-MM register access
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`include "rfm_params.svh"
module rfm_monitor
  import rfm_pkg::*;
#(
  parameter int NCNT = 4,
  parameter int QDEPTH = 128
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic flit_valid,
  input wire logic [2:0] flit_class,
  input wire logic flit_vn,
  input wire logic ring_ready,
  input wire logic queue_pop,
  output logic flit_to_ring,
  output logic flit_enqueued
);
  localparam int FW = 8;
  localparam int FB = 2 * FW;
  // queue events limited to the first four counters
  localparam int NEV = 4;

  // flit steering: straight to ring unless backed up
  logic [7:0] total_q;
  logic [2:0] head_cls_q [QDEPTH];
  logic head_vn_q [QDEPTH];
  logic [6:0] rd_ptr_q;
  logic [6:0] wr_ptr_q;
  wire logic q_empty = (total_q == 8'h00);
  wire logic q_full = (total_q == 8'(QDEPTH));
  wire logic bypass = flit_valid && ring_ready && q_empty;
  wire logic alloc = flit_valid && !bypass && !q_full;
  wire logic pop = queue_pop && !q_empty;
  wire logic [2:0] pop_cls = head_cls_q[rd_ptr_q];
  wire logic pop_vn = head_vn_q[rd_ptr_q];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      total_q <= '0;
    end else begin
      if (alloc) begin
        wr_ptr_q <= wr_ptr_q + 7'h01;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 7'h01;
      end
      total_q <= total_q + 8'(alloc) - 8'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (alloc) begin
      head_cls_q[wr_ptr_q] <= flit_class;
      head_vn_q[wr_ptr_q] <= flit_vn;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flit_to_ring <= 1'b0;
      flit_enqueued <= 1'b0;
    end else begin
      flit_to_ring <= bypass;
      flit_enqueued <= alloc;
    end
  end

  logic [6*FB-1:0] fill_flat;
  rfm_fill_tracker #(
    .CW(FW)
  ) u_fill (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .alloc_valid(alloc),
    .alloc_class(flit_class),
    .alloc_vn(flit_vn),
    .free_valid(pop),
    .free_class(pop_cls),
    .free_vn(pop_vn),
    .fill_flat(fill_flat)
  );

  // control and counter registers
  logic [31:0] ctl_q [NCNT];
  logic [47:0] count [NCNT];
  logic wait_q;
  logic [31:0] rdata_q;

  wire logic acc = (avs_read || avs_write) && wait_q;
  wire logic rd_go = avs_read && wait_q;
  wire logic is_ctl = (avs_address[7:4] == 4'h0);
  wire logic is_cnt = (avs_address[7:4] == 4'h1);
  wire logic is_stat = (avs_address == `RFM_OFF_STAT);
  wire logic is_qsize = (avs_address == `RFM_OFF_QSIZE);
  wire logic [1:0] sel_idx = is_ctl ? avs_address[3:2] : avs_address[3:2];
  wire logic [1:0] word_idx = avs_address[3:2];
  wire logic wr_go = avs_write && !wait_q;


  // per-counter event selection
  genvar c;
  generate
    for (c = 0; c < NCNT; c++) begin : g_cnt
      wire logic [7:0] code = ctl_q[c][`RFM_CTL_CODE_LSB +: 8];
      wire logic [1:0] vmask = ctl_q[c][`RFM_CTL_UMASK_LSB +: 2];
      wire logic xsel = ctl_q[c][`RFM_CTL_XSEL_BIT];
      wire logic en = ctl_q[c][`RFM_CTL_EN_BIT];
      wire logic ev_slot = (c < NEV);
      logic [2:0] cls;
      logic use_alloc;
      logic use_fill;

      // allocation and class occupancy event code decode
      always_comb begin
        cls = 3'(RFM_CLS_DATA_RESPONSE);
        use_alloc = 1'b0;
        use_fill = 1'b0;
        if (xsel) begin
          case (code)
            `RFM_EV_ALLOC_DRS: begin
              cls = 3'(RFM_CLS_DATA_RESPONSE);
              use_alloc = 1'b1;
            end
            `RFM_EV_ALLOC_HOM: begin
              cls = 3'(RFM_CLS_COHERENCE_REQUEST);
              use_alloc = 1'b1;
            end
            `RFM_EV_ALLOC_NCB: begin
              cls = 3'(RFM_CLS_NONCOHERENT_BYPASS);
              use_alloc = 1'b1;
            end
            `RFM_EV_ALLOC_NCS: begin
              cls = 3'(RFM_CLS_NONCOHERENT_STANDARD);
              use_alloc = 1'b1;
            end
            `RFM_EV_ALLOC_NDR: begin
              cls = 3'(RFM_CLS_NONDATA_RESPONSE);
              use_alloc = 1'b1;
            end
            `RFM_EV_ALLOC_SNP: begin
              cls = 3'(RFM_CLS_SNOOP);
              use_alloc = 1'b1;
            end
            `RFM_EV_FILL_DRS: begin
              cls = 3'(RFM_CLS_DATA_RESPONSE);
              use_fill = 1'b1;
            end
            `RFM_EV_FILL_HOM: begin
              cls = 3'(RFM_CLS_COHERENCE_REQUEST);
              use_fill = 1'b1;
            end
            `RFM_EV_FILL_NCB: begin
              cls = 3'(RFM_CLS_NONCOHERENT_BYPASS);
              use_fill = 1'b1;
            end
            `RFM_EV_FILL_NCS: begin
              cls = 3'(RFM_CLS_NONCOHERENT_STANDARD);
              use_fill = 1'b1;
            end
            default: begin
              use_alloc = 1'b0;
            end
          endcase
        end
      end

      wire logic fill_all = !xsel && (code == `RFM_EV_FILL_ALL);
      wire logic [FW-1:0] f0 = fill_flat[(2*cls)*FW +: FW];
      wire logic [FW-1:0] f1 = fill_flat[(2*cls+1)*FW +: FW];
      wire logic [FW-1:0] fsel = (vmask[0] ? f0 : '0)
          + (vmask[1] ? f1 : '0);
      wire logic vn_hit = (vmask[0] && !flit_vn)
          || (vmask[1] && flit_vn);
      wire logic a_hit = use_alloc && alloc && vn_hit
          && (flit_class == cls);

      // clamp occupancy increments
      wire logic [FW-1:0] fill_cls_inc = (fsel > `RFM_MAX_FILL_INC)
          ? `RFM_MAX_FILL_INC : fsel;
      wire logic [FW-1:0] fill_all_inc = (total_q > `RFM_MAX_FILL_INC)
          ? `RFM_MAX_FILL_INC : total_q;
      rfm_sel_e mode;
      logic [FW-1:0] inc;

      // one event source per counter
      always_comb begin
        mode = RFM_SEL_NONE;
        if (use_alloc) begin
          mode = RFM_SEL_ALLOC;
        end else if (use_fill) begin
          mode = RFM_SEL_FILL_CLASS;
        end else if (fill_all) begin
          mode = RFM_SEL_FILL_ALL;
        end
      end

      always_comb begin
        inc = '0;
        case (mode)
          RFM_SEL_ALLOC: begin
            inc = a_hit ? 8'h01 : 8'h00;
          end
          RFM_SEL_FILL_CLASS: begin
            inc = fill_cls_inc;
          end
          RFM_SEL_FILL_ALL: begin
            inc = fill_all_inc;
          end
          default: begin
            inc = '0;
          end
        endcase
      end

      wire logic wctl = wr_go && is_ctl && word_idx == 2'(c);
      wire logic wlo = wr_go && is_cnt && avs_address[3:2] == 2'(c)
          && 1'b0;

      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          ctl_q[c] <= `RFM_CTL_RST;
        end else if (wctl) begin
          ctl_q[c] <= avs_writedata;
        end
      end
      rfm_counter #(
        .CW(48),
        .FW(FW)
      ) u_cnt (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .enable(en && ev_slot),
        .inc(inc),
        .wr_lo(wlo),
        .wr_hi(1'b0),
        .wdata(avs_writedata),
        .count(count[c])
      );
    end
  endgenerate

  // read mux; counters read as low word at 0x10+4n, read-only and cleared only by reset
  wire logic [31:0] ctl_word = ctl_q[sel_idx];
  wire logic [31:0] cnt_word = count[word_idx][31:0];
  wire logic [31:0] stat_word = {31'h0000_0000, q_empty};
  wire logic [31:0] qsize_word = {24'h00_0000, total_q};

  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (is_ctl) begin
      rmux = ctl_word;
    end else if (is_cnt) begin
      rmux = cnt_word;
    end else if (is_stat) begin
      rmux = stat_word;
    end else if (is_qsize) begin
      rmux = qsize_word;
    end
  end

  // one wait cycle, then answer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= !acc;
      // read data only moves on a read
      if (rd_go) begin
        rdata_q <= rmux;
      end
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
endmodule

// ==== logic/rfm_params.svh ====
// offsets, field positions, event codes and reset values of the monitor
`ifndef RFM_PARAMS_SVH
`define RFM_PARAMS_SVH
`define RFM_OFF_CTL0 8'h00
`define RFM_OFF_CNT0 8'h10
`define RFM_OFF_STAT 8'h20
`define RFM_OFF_QSIZE 8'h24
`define RFM_CTL_CODE_LSB 0
`define RFM_CTL_UMASK_LSB 8
`define RFM_CTL_XSEL_BIT 21
`define RFM_CTL_EN_BIT 22
`define RFM_CTL_RST 32'h0000_0000
`define RFM_EV_ALLOC_DRS 8'h09
`define RFM_EV_ALLOC_NCB 8'h0a
`define RFM_EV_ALLOC_NCS 8'h0b
`define RFM_EV_ALLOC_HOM 8'h0c
`define RFM_EV_ALLOC_SNP 8'h0d
`define RFM_EV_ALLOC_NDR 8'h0e
`define RFM_EV_FILL_ALL 8'h0b
`define RFM_EV_FILL_DRS 8'h15
`define RFM_EV_FILL_NCB 8'h16
`define RFM_EV_FILL_NCS 8'h17
`define RFM_EV_FILL_HOM 8'h18
`define RFM_MAX_FILL_INC 8'h80
`endif

// ==== logic/rfm_pkg.sv ====
// types shared by the receive queue monitor
package rfm_pkg;
  typedef enum logic [2:0] {
    RFM_CLS_DATA_RESPONSE,
    RFM_CLS_COHERENCE_REQUEST,
    RFM_CLS_NONCOHERENT_BYPASS,
    RFM_CLS_NONCOHERENT_STANDARD,
    RFM_CLS_NONDATA_RESPONSE,
    RFM_CLS_SNOOP
  } rfm_class_e;
  typedef enum logic [1:0] {
    RFM_SEL_NONE,
    RFM_SEL_ALLOC,
    RFM_SEL_FILL_CLASS,
    RFM_SEL_FILL_ALL
  } rfm_sel_e;
endpackage

// ==== testbench/rfm_monitor_bench.sv ====
// self-checking bench for the receive queue monitor
module rfm_monitor_bench import rfm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] EN = 32'h0040_0000;
  localparam logic [31:0] XS = 32'h0020_0000;
  localparam logic [7:0] ACODE [6] = '{8'h09, 8'h0c, 8'h0a, 8'h0b,
                                       8'h0e, 8'h0d};
  localparam logic [7:0] VM [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
  localparam int EXP [4] = '{1, 1, 2, 0};
  logic ref_clk = 0, resetn = 0, rd = 0, wr = 0, fv = 0, fvn = 0, rr = 1;
  logic pop = 0, wrq, f2r, fenq;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rdata;
  logic [2:0] fcls = 0;
  int n_fail = 0, checked = 0, cyc = 0;
  rfm_monitor i_dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wrq), .flit_valid(fv), .flit_class(fcls),
    .flit_vn(fvn), .ring_ready(rr), .queue_pop(pop),
    .flit_to_ring(f2r), .flit_enqueued(fenq));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wrq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 0;
    wr <= 0;
    if (n >= 50) begin
      n_fail++;
      end_sim();
    end
    @(posedge ref_clk);
  endtask
  task automatic wr32(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(string s, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    cmp(s, e, q);
  endtask
  task automatic flit(logic [2:0] c, logic v);
    fv <= 1;
    fcls <= c;
    fvn <= v;
    @(posedge ref_clk);
  endtask
  task automatic pops(int k);
    pop <= 1;
    repeat (k) @(posedge ref_clk);
    pop <= 0;
  endtask
  initial begin
    int i, n, t0, t1, h;
    repeat (5) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    rchk("ctl1", 8'h04, 32'h0000_0000);
    rchk("status", 8'h20, 32'h0000_0001);
    wr32(8'h40, 32'h1234_5678);
    rchk("unmapped", 8'h40, 32'h0000_0000);
    wr32(8'h00, EN | XS | 32'h0000_0309);
    flit(3'd0, 1'b0);
    fv <= 0;
    #1 cmp("bypass", 32'h0000_0002, {30'h0, f2r, fenq});
    @(posedge ref_clk);
    rchk("cnt0 bypass", 8'h10, 32'h0000_0000);
    wr32(8'h00, 32'h0000_0000);
    $display("bypass test done");
    for (i = 0; i < 6; i++) begin
      for (n = 0; n < 4; n++) begin
        wr32(8'(4 * n), EN | XS | (32'(VM[n]) << 8) | 32'(ACODE[i]));
      end
      for (n = 0; n < 12; n++) begin
        rr <= (n > 0);
        flit(3'(n % 6), 1'(n / 6));
      end
      fv <= 0;
      rr <= 0;
      pops(12);
      for (n = 0; n < 4; n++) wr32(8'(4 * n), 32'h0000_0000);
      for (n = 0; n < 4; n++) begin
        rchk("alloc", 8'(16 + 4 * n),
             32'((i + 1) * EXP[n]));
      end
    end
    $display("alloc test done");
    wr32(8'h00, EN | XS | 32'h0000_0118);
    wr32(8'h04, EN | XS | 32'h0000_0317);
    wr32(8'h08, EN | XS | 32'h0000_0115);
    wr32(8'h0c, EN | 32'h0000_030b);
    flit(3'd0, 1'b0);
    flit(3'd1, 1'b0);
    fv <= 0;
    t0 = cyc;
    rchk("queue size", 8'h24, 32'h0000_0002);
    rchk("status", 8'h20, 32'h0000_0000);
    t1 = cyc;
    pops(2);
    wr32(8'h00, 32'h0000_0000);
    wr32(8'h04, 32'h0000_0000);
    wr32(8'h08, 32'h0000_0000);
    wr32(8'h0c, 32'h0000_0000);
    h = t1 - t0 + 2;
    rchk("fill class", 8'h18, 32'(12 + h));
    rchk("fill all", 8'h1c, 32'(2 * h));
    rchk("fill hom", 8'h10, 32'(6 + h));
    rchk("fill ncs", 8'h14, 32'h0000_0006);
    wr32(8'h10, 32'hffff_ffff);
    rchk("cnt0 ro", 8'h10, 32'(6 + h));
    $display("fill test done");
    end_sim();
  end
endmodule

// ==== testbench/rfm_monitor_sva.sv ====
// port assertions for the receive queue monitor
module rfm_monitor_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic flit_valid,
  input wire logic ring_ready,
  input wire logic flit_to_ring,
  input wire logic flit_enqueued
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire req = avs_read || avs_write;
  property p_wait_answer;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_wait_cause;
    !avs_waitrequest |-> req && $past(req);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("stray answer");
  property p_rdata_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_stall_no_bypass;
    flit_valid && !ring_ready |=> !flit_to_ring;
  endproperty
  a_stall_no_bypass: assert property (p_stall_no_bypass)
    else $error("bypass while ring stalled");
  property p_idle_quiet;
    !flit_valid |=> !flit_to_ring && !flit_enqueued;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("pulse without flit");
  property p_one_path;
    !(flit_to_ring && flit_enqueued);
  endproperty
  a_one_path: assert property (p_one_path)
    else $error("flit both bypassed and queued");
  property p_bypass_cause;
    flit_to_ring |-> $past(flit_valid) && $past(ring_ready);
  endproperty
  a_bypass_cause: assert property (p_bypass_cause)
    else $error("bypass without ready ring");
endmodule
bind rfm_monitor rfm_monitor_sva i_sva (.*);
